// ===== common/rpb_pkg.sv
// Shared constants, types and carriers for the downstream forwarding buffer.
// Assumes one 25 MHz clock; every user names items as rpb_pkg::name.
package rpb_pkg;

	// Channel id and multicast group widths
	localparam int CH_W  = 2;
	localparam int GRP_W = 32;

	// Transport packet framing
	localparam int          TS_LEN      = 188;
	localparam logic [7:0]  TS_LAST     = 8'(TS_LEN - 1);
	localparam logic [7:0]  TS_SYNC     = 8'h47;
	localparam logic [12:0] NULL_PID    = 13'h1FFF;
	localparam logic [7:0]  NULL_PID_HI = {3'h0, NULL_PID[12:8]};
	localparam logic [7:0]  NULL_PID_LO = NULL_PID[7:0];
	localparam logic [7:0]  NULL_CTRL   = 8'h10;
	localparam logic [7:0]  NULL_FILL   = 8'hFF;

	// Byte positions inside a transport packet
	localparam logic [7:0] POS_SYNC   = 8'h00;
	localparam logic [7:0] POS_PID_HI = 8'h01;
	localparam logic [7:0] POS_PID_LO = 8'h02;
	localparam logic [7:0] POS_CTRL   = 8'h03;

	// Clock rate and forwarding time bounds
	localparam int CLK_HZ   = 25_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int LAT_US   = 200;
	localparam int SKEW_US  = 500;
	localparam int LAT_CYC  = LAT_US * (CLK_HZ / US_PER_S);
	localparam int SKEW_CYC = SKEW_US * (CLK_HZ / US_PER_S);

	// Buffer holding times per channel type
	localparam int MS_PER_S     = 1000;
	localparam int BUF_DATA_MS  = 8;
	localparam int BUF_VIDEO_MS = 10;
	localparam int RATE_BPS     = 5_000_000;

	// Multicast streams held per RF port
	localparam int MC_SLOTS = 16;

	// Clocking mode of a channel
	typedef enum logic {
		RPB_SYNC  = 1'b0,
		RPB_ASYNC = 1'b1
	} rpb_clk_mode_t;

	// Ingress packet state
	typedef enum logic [1:0] {
		RPB_ING_IDLE = 2'b00,
		RPB_ING_TAKE = 2'b01,
		RPB_ING_DROP = 2'b10
	} rpb_ing_state_t;

	// One byte of a deframed pseudowire payload
	typedef struct packed {
		logic             valid;
		logic             first;
		logic             last;
		logic [CH_W-1:0]  chan;
		logic             mc;
		logic [GRP_W-1:0] group;
		logic [7:0]       data;
	} rpb_in_t;

	// Multicast join or leave, request and report
	typedef struct packed {
		logic             valid;
		logic             is_join;
		logic [GRP_W-1:0] group;
	} rpb_mc_t;

	// One byte towards the RF modulator
	typedef struct packed {
		logic       valid;
		logic       sop;
		logic       null_pkt;
		logic [7:0] data;
	} rpb_rf_t;

	// Sticky per-channel status
	typedef struct packed {
		logic overflow;
		logic late;
	} rpb_stat_t;

endpackage

// ===== logic/rpb_chan.sv
// Per-channel packet store with commit/rollback and RF egress with null fill.
// Assumes whole packets are committed by the ingress and rf_tick is on clk.
`timescale 1ns/1ns
module rpb_chan #(
	parameter int AW = 16
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// Write side
	input  wire logic            wr_en,
	input  wire logic [7:0]      wr_data,
	input  wire logic            wr_commit,
	input  wire logic            wr_abort,
	output logic                 space_ok,
	output logic                 has_pkt,
	// RF side
	input  wire logic            rf_tick,
	output rpb_pkg::rpb_rf_t     rf_out,
	output logic                 pkt_start
);

	localparam int             DEPTH     = 1 << AW;
	localparam logic [AW:0]    SPACE_MIN = (AW+1)'(DEPTH - rpb_pkg::TS_LEN);

	logic [7:0]        mem [DEPTH];          // Packet store
	logic [AW:0]       wr_ptr, next_wr_ptr;  // Speculative write point
	logic [AW:0]       cm_ptr, next_cm_ptr;  // End of committed packets
	logic [AW:0]       rd_ptr, next_rd_ptr;  // Egress read point
	logic [7:0]        idx, next_idx;        // Byte position on RF side
	logic              from_buf, next_from_buf;
	rpb_pkg::rpb_rf_t  next_rf;
	logic [AW:0]       used;                 // Bytes held incl. uncommitted

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	assign used      = wr_ptr - rd_ptr;
	assign space_ok  = used <= SPACE_MIN;
	assign has_pkt   = cm_ptr != rd_ptr;
	assign pkt_start = rf_out.valid & rf_out.sop & ~rf_out.null_pkt;

	////////////////////////////////////////////////////////////////////////
	// Next pointers and RF byte
	always_comb begin
		next_wr_ptr   = wr_ptr;
		next_cm_ptr   = cm_ptr;
		next_rd_ptr   = rd_ptr;
		next_idx      = idx;
		next_from_buf = from_buf;
		next_rf       = rf_out;
		next_rf.valid = 1'b0;
		// Rollback discards the whole packet
		if (wr_abort) begin
			next_wr_ptr = cm_ptr;
		end else if (wr_en) begin
			next_wr_ptr = wr_ptr + 1'b1;
			if (wr_commit) begin
				next_cm_ptr = wr_ptr + 1'b1;
			end
		end
		if (rf_tick) begin
			next_rf.valid = 1'b1;
			next_rf.sop   = idx == rpb_pkg::POS_SYNC;
			// RULE9 null insertion on underrun
			if (idx == rpb_pkg::POS_SYNC) begin
				next_from_buf = has_pkt;
			end
			next_rf.null_pkt = ~next_from_buf;
			if (next_from_buf) begin
				next_rf.data = mem[rd_ptr[AW-1:0]];
				next_rd_ptr  = rd_ptr + 1'b1;
			end else begin
				case (idx)
					rpb_pkg::POS_SYNC:   next_rf.data = rpb_pkg::TS_SYNC;
					rpb_pkg::POS_PID_HI: next_rf.data = rpb_pkg::NULL_PID_HI;
					rpb_pkg::POS_PID_LO: next_rf.data = rpb_pkg::NULL_PID_LO;
					rpb_pkg::POS_CTRL:   next_rf.data = rpb_pkg::NULL_CTRL;
					default:             next_rf.data = rpb_pkg::NULL_FILL;
				endcase
			end
			// RULE10 packets leave whole
			next_idx = (idx == rpb_pkg::TS_LAST) ? 8'h00 : idx + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register pointers and output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr   <= '0;
			cm_ptr   <= '0;
			rd_ptr   <= '0;
			idx      <= 8'h00;
			from_buf <= 1'b0;
			rf_out   <= '0;
		end else begin
			wr_ptr   <= next_wr_ptr;
			cm_ptr   <= next_cm_ptr;
			rd_ptr   <= next_rd_ptr;
			idx      <= next_idx;
			from_buf <= next_from_buf;
			rf_out   <= next_rf;
		end
	end

	// Store write, no reset needed
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_ptr[AW-1:0]] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_gap;
		rf_tick && idx == rpb_pkg::POS_SYNC && !has_pkt;
	endsequence

	null_fill_a: assert property ( // RULE9
		s_gap |=> rf_out.null_pkt && rf_out.sop && rf_out.data == rpb_pkg::TS_SYNC)
		else $error("empty slot not filled with a null packet");

	whole_pkt_a: assert property ( // RULE10
		rf_tick && idx != rpb_pkg::POS_SYNC |=> from_buf == $past(from_buf))
		else $error("packet source switched mid packet");

endmodule // rpb_chan

// ===== logic/rpb_fwd.sv
// Downstream forwarding buffer: per-channel stores, null handling, latency
// watch and multicast membership for the RF ports of a remote PHY node.
// Assumes net_in and rf_tick come from logic on clk; bytes are deframed.
// Function
// RULE1: Isolated data packets forwarded under 200 us
// RULE2: Stream mode latency from frame-carrying packet end
// RULE3: Transport modes latency to first carried packet
// RULE4: Bonded channel skew below 500 us
// RULE5: Data channel store holds 8 ms
// RULE6: Video channel store holds 10 ms
// RULE7: Latency bound covers data channels only
// RULE8: Source spaces isolated packets apart
// RULE9: Insert or delete null packets as needed
// RULE10: Timestamps leave compliant, packets kept whole
// RULE11: Core sends constant rate video padded
// RULE12: Core sends exactly the configured rate
// RULE13: Synchronous mode always, asynchronous optional
// RULE14: Core keeps within advertised async count
// RULE15: Join and leave multicast, sixteen streams
// RULE16: Full buffer drops packet, sticky overflow
`timescale 1ns/1ns
module rpb_fwd #(
	parameter int NCH         = 4,
	parameter int RATE        = rpb_pkg::RATE_BPS,
	parameter int LAT_CYCLES  = rpb_pkg::LAT_CYC,
	parameter int SKEW_CYCLES = rpb_pkg::SKEW_CYC,
	parameter int ASYNC_CAP   = NCH
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Network ingress
	input  wire rpb_pkg::rpb_in_t          net_in,
	// Channel configuration
	input  wire logic [NCH-1:0]            video_mode,
	input  wire logic [NCH-1:0]            async_req,
	output logic [NCH-1:0]                 async_on,
	// Multicast signalling
	input  wire rpb_pkg::rpb_mc_t          mc_req,
	output rpb_pkg::rpb_mc_t               mc_report,
	output logic                           mc_full,
	// RF outputs
	input  wire logic [NCH-1:0]            rf_tick,
	output rpb_pkg::rpb_rf_t [NCH-1:0]     rf_out,
	// Status
	input  wire logic [NCH-1:0]            stat_clr,
	output rpb_pkg::rpb_stat_t [NCH-1:0]   stat
);

	// RULE5 data holding depth
	localparam int NEED_D = RATE / rpb_pkg::MS_PER_S * rpb_pkg::BUF_DATA_MS;
	// RULE6 video holding depth
	localparam int NEED_V = RATE / rpb_pkg::MS_PER_S * rpb_pkg::BUF_VIDEO_MS;
	localparam int AW     = $clog2(NEED_V + rpb_pkg::TS_LEN);
	localparam int LW     = $clog2(SKEW_CYCLES + 2);
	localparam int SW     = $clog2(rpb_pkg::MC_SLOTS);
	localparam logic [LW-1:0] LAT_LIM = LW'(LAT_CYCLES);

	// Ingress state
	rpb_pkg::rpb_ing_state_t st, next_st;
	logic [7:0]            idx, next_idx;        // Byte position in packet
	logic [4:0]            pid_hi, next_pid_hi;  // Upper packet id bits
	logic                  is_null, next_is_null;
	logic [rpb_pkg::CH_W-1:0] cur_ch, next_ch;   // Channel of this packet
	logic [rpb_pkg::CH_W-1:0] sel_ch;            // Channel for this byte
	logic [7:0]            pos;                  // Position of this byte
	logic                  take;                 // Byte goes to the store

	// Per-channel strobes and flags
	logic [NCH-1:0]        wr_en;
	logic [NCH-1:0]        wr_commit;
	logic [NCH-1:0]        wr_abort;
	logic [NCH-1:0]        drop_ev;              // Packet refused for space
	logic [NCH-1:0]        space_ok;
	logic [NCH-1:0]        has_pkt;
	logic [NCH-1:0]        pkt_start;

	// Multicast table
	logic [rpb_pkg::MC_SLOTS-1:0] mv, next_mv;   // Slot in use
	logic [rpb_pkg::GRP_W-1:0]    mg [rpb_pkg::MC_SLOTS];
	logic [rpb_pkg::GRP_W-1:0]    next_mg [rpb_pkg::MC_SLOTS];
	rpb_pkg::rpb_mc_t             next_rep;
	logic                         next_full;
	logic                         grp_hit;       // Ingress group joined
	logic                         req_hit;       // Request group joined
	logic                         free_any;
	logic [SW-1:0]                free_idx;
	logic [SW-1:0]                hit_idx;

	// Latency watch and status
	logic [NCH-1:0]               lat_run, next_run;
	logic [NCH-1:0][LW-1:0]       lat_cnt, next_cnt;
	rpb_pkg::rpb_stat_t [NCH-1:0] next_stat;
	logic [NCH-1:0]               next_async;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Ingress admission, null deletion and commit
	always_comb begin
		next_st      = st;
		next_idx     = idx;
		next_pid_hi  = pid_hi;
		next_is_null = is_null;
		next_ch      = cur_ch;
		wr_en        = '0;
		wr_commit    = '0;
		wr_abort     = '0;
		drop_ev      = '0;
		sel_ch       = net_in.first ? net_in.chan : cur_ch;
		pos          = net_in.first ? rpb_pkg::POS_SYNC : idx;
		take         = 1'b0;
		if (net_in.valid && (net_in.first || st != rpb_pkg::RPB_ING_IDLE)) begin
			if (net_in.first) begin
				if (net_in.mc && !grp_hit) begin
					// Group not joined: discard quietly
					take = 1'b0;
				end else if (!space_ok[sel_ch]) begin
					// RULE16 refuse when full
					drop_ev[sel_ch] = 1'b1;
				end else begin
					take = 1'b1;
				end
			end else begin
				take = st == rpb_pkg::RPB_ING_TAKE;
			end
			next_ch  = sel_ch;
			next_idx = pos + 8'h01;
			next_st  = take ? rpb_pkg::RPB_ING_TAKE : rpb_pkg::RPB_ING_DROP;
			// Capture packet id for null detection
			if (pos == rpb_pkg::POS_PID_HI) begin
				next_pid_hi = net_in.data[4:0];
			end
			if (pos == rpb_pkg::POS_PID_LO) begin
				next_is_null = {pid_hi, net_in.data} == rpb_pkg::NULL_PID;
			end
			wr_en[sel_ch] = take;
			if (net_in.last) begin
				next_st = rpb_pkg::RPB_ING_IDLE;
				if (take) begin
					// RULE9 async deletes incoming nulls
					if (pos != rpb_pkg::TS_LAST || (is_null && async_on[sel_ch])) begin
						wr_abort[sel_ch] = 1'b1;
					end else begin
						// RULE2 ready at last input byte
						wr_commit[sel_ch] = 1'b1;
					end
				end
			end else if (take && pos == rpb_pkg::TS_LAST) begin
				// Oversize packet: roll back, drop rest
				wr_abort[sel_ch] = 1'b1;
				next_st          = rpb_pkg::RPB_ING_DROP;
			end
		end
	end

	// Register ingress state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st      <= rpb_pkg::RPB_ING_IDLE;
			idx     <= 8'h00;
			pid_hi  <= 5'h00;
			is_null <= 1'b0;
			cur_ch  <= '0;
		end else begin
			st      <= next_st;
			idx     <= next_idx;
			pid_hi  <= next_pid_hi;
			is_null <= next_is_null;
			cur_ch  <= next_ch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Multicast membership table
	always_comb begin
		next_mv         = mv;
		next_mg         = mg;
		next_rep        = mc_report;
		next_rep.valid  = 1'b0;
		next_full       = 1'b0;
		grp_hit         = 1'b0;
		req_hit         = 1'b0;
		free_any        = 1'b0;
		free_idx        = '0;
		hit_idx         = '0;
		// Lowest free slot wins
		for (int i = rpb_pkg::MC_SLOTS - 1; i >= 0; i--) begin
			if (mv[i] && mg[i] == net_in.group) begin
				grp_hit = 1'b1;
			end
			if (mv[i] && mg[i] == mc_req.group) begin
				req_hit = 1'b1;
				hit_idx = SW'(i);
			end
			if (!mv[i]) begin
				free_any = 1'b1;
				free_idx = SW'(i);
			end
		end
		// RULE15 join and leave
		if (mc_req.valid) begin
			if (mc_req.is_join && !req_hit) begin
				if (free_any) begin
					next_mv[free_idx] = 1'b1;
					next_mg[free_idx] = mc_req.group;
					next_rep          = {1'b1, 1'b1, mc_req.group};
				end else begin
					next_full = 1'b1;
				end
			end else if (!mc_req.is_join && req_hit) begin
				next_mv[hit_idx] = 1'b0;
				next_rep         = {1'b1, 1'b0, mc_req.group};
			end
		end
	end

	// Register multicast table
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mv        <= '0;
			mg        <= '{default: '0};
			mc_report <= '0;
			mc_full   <= 1'b0;
		end else begin
			mv        <= next_mv;
			mg        <= next_mg;
			mc_report <= next_rep;
			mc_full   <= next_full;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode gating, latency watch and sticky status
	always_comb begin
		next_async = '0;
		next_stat  = stat;
		next_run   = lat_run;
		next_cnt   = lat_cnt;
		for (int c = 0; c < NCH; c++) begin
			// RULE13 sync default, async when capable
			// RULE14 capability limit enforced
			next_async[c] = async_req[c] && (c < ASYNC_CAP);
			// Clear first so a same-cycle event wins
			if (stat_clr[c]) begin
				next_stat[c] = '0;
			end
			// RULE16 sticky overflow
			if (drop_ev[c]) begin
				next_stat[c].overflow = 1'b1;
			end
			if (lat_run[c]) begin
				if (lat_cnt[c] != '1) begin
					next_cnt[c] = lat_cnt[c] + 1'b1;
				end
				// RULE1 bound missed
				if (lat_cnt[c] >= LAT_LIM) begin
					next_stat[c].late = 1'b1;
				end
				// RULE3 stop at first carried byte
				if (pkt_start[c]) begin
					next_run[c] = 1'b0;
				end
			end
			// RULE7 only data channels watched
			if (wr_commit[c] && !has_pkt[c] && !video_mode[c]) begin
				next_run[c] = 1'b1;
				next_cnt[c] = '0;
			end
		end
	end

	// Register watch and status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			async_on <= '0;
			stat     <= '0;
			lat_run  <= '0;
			lat_cnt  <= '0;
		end else begin
			async_on <= next_async;
			stat     <= next_stat;
			lat_run  <= next_run;
			lat_cnt  <= next_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel stores; sync mode passes core nulls through at core rate
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		// RULE4 equal path per channel
		rpb_chan #(.AW(AW)) u_chan (
			.clk       (clk),
			.rst_n     (rst_n),
			.wr_en     (wr_en[g]),
			.wr_data   (net_in.data),
			.wr_commit (wr_commit[g]),
			.wr_abort  (wr_abort[g]),
			.space_ok  (space_ok[g]),
			.has_pkt   (has_pkt[g]),
			.rf_tick   (rf_tick[g]),
			.rf_out    (rf_out[g]),
			.pkt_start (pkt_start[g])
		);
		sequence s_iso_commit;
			wr_commit[g] && !has_pkt[g] && !video_mode[g];
		endsequence
		// A stalled RF side may hold a packet past the bound; it must be flagged
		lat_bound_a: assert property ( // RULE1
			lat_run[g] && lat_cnt[g] >= LAT_LIM |=> stat[g].late)
			else $error("missed latency bound not flagged");
		lat_start_a: assert property ( // RULE2
			s_iso_commit |=> lat_run[g] && lat_cnt[g] == '0)
			else $error("latency watch not started at commit");
		lat_stop_a: assert property ( // RULE3
			lat_run[g] && pkt_start[g] && !wr_commit[g] |=> !lat_run[g])
			else $error("latency watch not stopped at output");
		skew_a: assert property ( // RULE4
			lat_run[g] |-> lat_cnt[g] < LW'(SKEW_CYCLES))
			else $error("channel skew bound exceeded");
		video_free_a: assert property ( // RULE7
			video_mode[g] && !lat_run[g] |=> !lat_run[g])
			else $error("video channel under latency watch");
		ovf_hold_a: assert property ( // RULE16
			drop_ev[g] |=> stat[g].overflow ##1 (stat[g].overflow || $past(stat_clr[g])))
			else $error("overflow not sticky after drop");
		async_gate_a: assert property ( // RULE13
			async_on[g] |-> (g < ASYNC_CAP) && $past(async_req[g]))
			else $error("asynchronous mode beyond capability");
	end

	depth_a: assert property ( // RULE5 RULE6
		(2 ** AW) >= NEED_D + rpb_pkg::TS_LEN && (2 ** AW) >= NEED_V + rpb_pkg::TS_LEN)
		else $error("channel store too small");
	sequence s_join_new;
		mc_req.valid && mc_req.is_join && !req_hit && free_any;
	endsequence
	mc_join_a: assert property ( // RULE15
		s_join_new |=> mc_report.valid && mc_report.is_join
			&& mc_report.group == $past(mc_req.group)
			##1 req_hit || mc_req.group != $past(mc_req.group, 2))
		else $error("join not recorded");
	mc_leave_a: assert property ( // RULE15
		mc_req.valid && !mc_req.is_join && req_hit |=> mc_report.valid && !mc_report.is_join)
		else $error("leave not reported");
endmodule // rpb_fwd

// ===== testbench/rpb_core_model.sv
// Model of the remote core device that feeds deframed pseudowire bytes.
// Assumes the bench clock; its task is called from the testbench top.
`timescale 1ns/1ns
module rpb_core_model (
	// Clock
	input  wire logic        clk,
	// Bytes towards the node
	output rpb_pkg::rpb_in_t net_in
);
	// Byte i of a packet: sync, 13-bit id, control, then a pattern
	function automatic logic [7:0] pkt_byte(input logic [12:0] pid, input logic [7:0] fill,
		input int i);
		case (i)
			0: return 8'h47;
			1: return {3'h0, pid[12:8]};
			2: return pid[7:0];
			3: return 8'h10;
			default: return fill ^ 8'(i);
		endcase
	endfunction

	// Bus idle at time zero
	initial begin
		net_in = '0;
	end

	// steady byte rate
	// Sends len bytes, one a cycle, called just after a rising edge
	task automatic send_pkt(input logic [1:0] ch, input logic [12:0] pid, input logic mc,
		input logic [31:0] grp, input logic [7:0] fill, input int len);
		for (int i = 0; i < len; i++) begin
			net_in = '{valid: 1'b1, first: i == 0, last: i == len - 1, chan: ch, mc: mc,
				group: grp, data: pkt_byte(pid, fill, i)};
			@(posedge clk);
			#1;
		end
		// Released bus shows inverted data, never the last value
		net_in = '{valid: 1'b0, first: 1'b0, last: 1'b0, chan: ~ch, mc: 1'b0,
			group: ~grp, data: ~net_in.data};
		@(posedge clk);
		#1;
	endtask
endmodule // rpb_core_model

// ===== testbench/testbench.sv
// Self-checking bench for the downstream forwarding buffer.
// Assumes rpb_pkg and rpb_core_model are compiled before this file.
`timescale 1ns/1ns
module testbench;
	// Clock, reset and ports
	logic                     clk;
	logic                     rst_n;
	rpb_pkg::rpb_in_t         net_in;
	logic [3:0]               video_mode;
	logic [3:0]               async_req;
	logic [3:0]               async_on;
	rpb_pkg::rpb_mc_t         mc_req;
	rpb_pkg::rpb_mc_t         mc_report;
	logic                     mc_full;
	logic [3:0]               rf_tick;
	rpb_pkg::rpb_rf_t [3:0]   rf_out;
	logic [3:0]               stat_clr;
	rpb_pkg::rpb_stat_t [3:0] stat;
	// Bookkeeping
	int                       err_total = 0;
	int                       check_count = 0;
	int                       cyc = 0;

	// Far side feeding the network port
	rpb_core_model core_u (.clk(clk), .net_in(net_in));

	// Small store (512 bytes) and latency limit keep the run short
	rpb_fwd #(.NCH(4), .RATE(10000), .LAT_CYCLES(300), .SKEW_CYCLES(600), .ASYNC_CAP(2))
	dut_u (.clk(clk), .rst_n(rst_n), .net_in(net_in), .video_mode(video_mode),
		.async_req(async_req), .async_on(async_on), .mc_req(mc_req),
		.mc_report(mc_report), .mc_full(mc_full), .rf_tick(rf_tick), .rf_out(rf_out),
		.stat_clr(stat_clr), .stat(stat));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Four-state compare
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits n edges, then steps off the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Expected byte i of a sent packet
	function automatic logic [7:0] exp_byte(input logic [12:0] pid, input logic [7:0] fill,
		input int i);
		case (i)
			0: return 8'h47;
			1: return {3'h0, pid[12:8]};
			2: return pid[7:0];
			3: return 8'h10;
			default: return fill ^ 8'(i);
		endcase
	endfunction

	// Ticks one whole packet out of a channel; ins marks an inserted null
	task automatic read_pkt(input int ch, input logic [12:0] pid, input logic [7:0] fill,
		input logic ins);
		logic [7:0] b;
		rf_tick[ch] = 1'b1;
		for (int i = 0; i < 188; i++) begin
			step(1);
			if (i == 187)
				rf_tick[ch] = 1'b0;
			b = (ins && i > 3) ? 8'hFF : exp_byte(pid, fill, i);
			chk("rf byte", {1'b1, i == 0, ins, b}, {rf_out[ch].valid, rf_out[ch].sop,
				rf_out[ch].null_pkt, rf_out[ch].data});
		end
		step(1);
	endtask

	// One multicast request and its one-cycle answer
	task automatic mc(input logic jn, input logic [31:0] g, input logic rep, input logic full);
		mc_req = '{valid: 1'b1, is_join: jn, group: g};
		step(1);
		chk("mc valid full", {rep, full}, {mc_report.valid, mc_full});
		if (rep)
			chk("mc join group", {jn, g}, {mc_report.is_join, mc_report.group});
		mc_req = '0;
		step(1);
	endtask

	// Pulses a status clear
	task automatic clr(input int ch);
		stat_clr[ch] = 1'b1;
		step(1);
		stat_clr[ch] = 1'b0;
		step(1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios

	// Outputs quiet out of reset
	task automatic t_reset();
		chk("outputs", 48'h0, {stat, async_on, mc_report.valid, mc_full, rf_out[0].valid,
			rf_out[1].valid, rf_out[2].valid, rf_out[3].valid});
	endtask

	// Empty store sends a null packet
	task automatic t_null();
		read_pkt(0, 13'h1FFF, 8'hFF, 1'b1);
	endtask

	// Isolated data packet leaves in time, bytes unchanged
	task automatic t_fwd();
		core_u.send_pkt(2'h0, 13'h0100, 1'b0, 32'h0, 8'h5A, 188);
		read_pkt(0, 13'h0100, 8'h5A, 1'b0);
		chk("late ch0", 48'h0, stat[0].late);
	endtask

	// Packet held past the limit flags late; clear drops it
	task automatic t_late();
		core_u.send_pkt(2'h0, 13'h0101, 1'b0, 32'h0, 8'h11, 188);
		step(320);
		chk("late set", 48'h1, stat[0].late);
		read_pkt(0, 13'h0101, 8'h11, 1'b0);
		clr(0);
		chk("late clr", 48'h0, stat[0].late);
	endtask

	// Short and oversize packets are dropped whole
	task automatic t_badlen();
		core_u.send_pkt(2'h0, 13'h0102, 1'b0, 32'h0, 8'h22, 100);
		core_u.send_pkt(2'h0, 13'h0103, 1'b0, 32'h0, 8'h23, 200);
		read_pkt(0, 13'h1FFF, 8'hFF, 1'b1);
	endtask

	// Async deletes nulls within its cap; sync video keeps them, no latency watch
	task automatic t_modes();
		async_req = 4'b1010;
		step(2);
		chk("async on", 48'h2, async_on);
		core_u.send_pkt(2'h1, 13'h1FFF, 1'b0, 32'h0, 8'h44, 188);
		core_u.send_pkt(2'h1, 13'h0022, 1'b0, 32'h0, 8'h22, 188);
		read_pkt(1, 13'h0022, 8'h22, 1'b0);
		core_u.send_pkt(2'h2, 13'h1FFF, 1'b0, 32'h0, 8'h33, 188);
		step(320);
		chk("late video", 48'h0, stat[2].late);
		read_pkt(2, 13'h1FFF, 8'h33, 1'b0);
	endtask

	// Third packet overflows the store; the first two survive
	task automatic t_ovf();
		for (int k = 0; k < 3; k++)
			core_u.send_pkt(2'h3, 13'(48 + k), 1'b0, 32'h0, 8'(k), 188);
		chk("overflow set", 48'h1, stat[3].overflow);
		clr(3);
		chk("overflow clr", 48'h0, stat[3].overflow);
		read_pkt(3, 13'd48, 8'h00, 1'b0);
		read_pkt(3, 13'd49, 8'h01, 1'b0);
		read_pkt(3, 13'h1FFF, 8'hFF, 1'b1);
	endtask

	// Sixteen joins, refusal, leave and rejoin, group filtering
	task automatic t_mcast();
		core_u.send_pkt(2'h0, 13'h0200, 1'b1, 32'hA5, 8'h66, 188);
		read_pkt(0, 13'h1FFF, 8'hFF, 1'b1);
		for (int k = 0; k < 16; k++)
			mc(1'b1, 32'hA0 + k, 1'b1, 1'b0);
		mc(1'b1, 32'hB0, 1'b0, 1'b1);
		mc(1'b0, 32'hA3, 1'b1, 1'b0);
		mc(1'b1, 32'hB0, 1'b1, 1'b0);
		core_u.send_pkt(2'h0, 13'h0200, 1'b1, 32'hA5, 8'h66, 188);
		read_pkt(0, 13'h0200, 8'h66, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard

	initial begin
		rst_n = 1'b0;
		video_mode = 4'b1100;
		async_req = '0;
		mc_req = '0;
		rf_tick = '0;
		stat_clr = '0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_null();
		t_fwd();
		t_late();
		t_badlen();
		t_modes();
		t_ovf();
		t_mcast();
		end_sim();
	end

	// Cuts a hang short well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
endmodule // testbench
